/* File: logic/pma_pkg.sv */
// Package for program memory addressing block
package pma_pkg;
   localparam int PC_W = 13;
   localparam int INSTR_W = 14;
   localparam int PHYS_AW = 10;
   localparam int PHYS_WORDS = 1024;
   localparam int DATA_W = 8;
   localparam int DMEM_AW = 7;
   localparam int DMEM_WORDS = 128;
   localparam int SFR_COUNT = 12;
   localparam int EE_AW = 6;
   localparam int EE_WORDS = 64;
   localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
   localparam logic [PC_W-1:0] INT_VEC = 13'h0004;
   localparam logic [1:0] QPH_RST = 2'h0;
   localparam logic [1:0] QPH_LAST = 2'h3;
endpackage

/* File: logic/pma_core.sv */
// Program memory addressing, data bus and data EEPROM array
`timescale 1ns/100ps
module pma_core
   import pma_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic master_reset_n_in,
   // Oscillator mode
   input wire logic rc_mode_in,
   output logic instr_rate_out,
   // Program flow control
   input wire logic branch_in,
   input wire logic [PC_W-1:0] branch_addr_in,
   input wire logic irq_take_in,
   output logic [PC_W-1:0] pc_out,
   output logic [INSTR_W-1:0] instr_out,
   output logic fetch_out,
   // Program memory load port
   input wire logic pm_we_in,
   input wire logic [PC_W-1:0] pm_addr_in,
   input wire logic [INSTR_W-1:0] pm_wdata_in,
   // Data memory bus
   input wire logic dm_we_in,
   input wire logic dm_re_in,
   input wire logic [DMEM_AW-1:0] dm_addr_in,
   input wire logic [DATA_W-1:0] dm_wdata_in,
   output logic [DATA_W-1:0] dm_rdata_out,
   output logic dm_is_sfr_out,
   // Data EEPROM pointer port
   input wire logic ee_ptr_we_in,
   input wire logic [DATA_W-1:0] ee_ptr_in,
   input wire logic ee_we_in,
   input wire logic ee_re_in,
   input wire logic [DATA_W-1:0] ee_wdata_in,
   output logic [DATA_W-1:0] ee_rdata_out
);

   logic master_reset_n_meta;
   logic master_reset_n_sync;
   logic core_rst;
   logic [1:0] qphase;
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic [INSTR_W-1:0] pmem [PHYS_WORDS];
   logic [DATA_W-1:0] dmem [DMEM_WORDS];
   logic [DATA_W-1:0] eemem [EE_WORDS];
   logic [EE_AW-1:0] ee_ptr;
   logic fetch;

   // Pin passes two flops before use
   always_ff @(posedge clk_sys_in) begin
      master_reset_n_meta <= master_reset_n_in;
      master_reset_n_sync <= master_reset_n_meta;
   end

   assign core_rst = rst_in | ~master_reset_n_sync;

   // Quarter-rate instruction cycle phase
   always_ff @(posedge clk_sys_in) begin
      if (core_rst) begin
         qphase <= QPH_RST;
      end else begin
         qphase <= qphase + 2'h1;
      end
   end

   assign fetch = (qphase == QPH_LAST);

   // Output held low outside RC mode, crystal owns the pin then
   always_ff @(posedge clk_sys_in) begin
      if (core_rst) begin
         instr_rate_out <= 1'b0;
      end else begin
         instr_rate_out <= rc_mode_in & qphase[1];
      end
   end

   // Interrupt wins over branch so the vector is never skipped
   always_comb begin
      if (irq_take_in) begin
         next_pc = INT_VEC;
      end else if (branch_in) begin
         next_pc = branch_addr_in;
      end else begin
         next_pc = pc + 13'h0001;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (core_rst) begin
         pc <= RESET_VEC;
      end else if (fetch) begin
         pc <= next_pc;
      end
   end

   assign pc_out = pc;

   // Program bus: low ten bits index the array, upper bits alias
   always_ff @(posedge clk_sys_in) begin
      if (pm_we_in) begin
         pmem[pm_addr_in[PHYS_AW-1:0]] <= pm_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (core_rst) begin
         instr_out <= '0;
         fetch_out <= 1'b0;
      end else begin
         fetch_out <= fetch;
         if (fetch) begin
            instr_out <= pmem[pc[PHYS_AW-1:0]];
         end
      end
   end

   // Data bus is independent of the fetch path
   always_ff @(posedge clk_sys_in) begin
      if (dm_we_in) begin
         dmem[dm_addr_in] <= dm_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (core_rst) begin
         dm_rdata_out <= '0;
         dm_is_sfr_out <= 1'b0;
      end else if (dm_re_in) begin
         dm_rdata_out <= dmem[dm_addr_in];
         dm_is_sfr_out <= (dm_addr_in < DMEM_AW'(SFR_COUNT));
      end
   end

   // EEPROM only through pointer; upper pointer bits ignored
   always_ff @(posedge clk_sys_in) begin
      if (core_rst) begin
         ee_ptr <= '0;
      end else if (ee_ptr_we_in) begin
         ee_ptr <= ee_ptr_in[EE_AW-1:0];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (ee_we_in) begin
         eemem[ee_ptr] <= ee_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (core_rst) begin
         ee_rdata_out <= '0;
      end else if (ee_re_in) begin
         ee_rdata_out <= eemem[ee_ptr];
      end
   end

   property p_reset_vec;
      @(posedge clk_sys_in) core_rst |=> (pc == RESET_VEC);
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector");

   property p_irq_vec;
      @(posedge clk_sys_in) disable iff (core_rst)
         (fetch && irq_take_in) |=> (pc == INT_VEC);
   endproperty
   a_irq_vec: assert property (p_irq_vec) else $error("pc not at interrupt vector");

   property p_pc_inc;
      @(posedge clk_sys_in) disable iff (core_rst)
         (fetch && !irq_take_in && !branch_in) |=> (pc == $past(pc) + 13'h0001);
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("pc did not advance by one");

   property p_pc_hold;
      @(posedge clk_sys_in) disable iff (core_rst) !fetch |=> $stable(pc);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved between fetches");

   property p_fetch_alias;
      @(posedge clk_sys_in) disable iff (core_rst)
         (fetch && !pm_we_in) |=> (instr_out == pmem[$past(pc[PHYS_AW-1:0])]);
   endproperty
   a_fetch_alias: assert property (p_fetch_alias) else $error("fetch word wrong");

   property p_fetch_rate;
      @(posedge clk_sys_in) disable iff (core_rst) fetch |=> !fetch [*3] ##1 fetch;
   endproperty
   a_fetch_rate: assert property (p_fetch_rate) else $error("fetch not every fourth cycle");

   property p_instr_rate_out_quarter;
      @(posedge clk_sys_in) disable iff (core_rst || !rc_mode_in)
         (fetch && rc_mode_in) |=> instr_rate_out ##1 !instr_rate_out ##1 !instr_rate_out ##1 instr_rate_out;
   endproperty
   a_instr_rate_out_quarter: assert property (p_instr_rate_out_quarter) else $error("rate output wrong");

   property p_master_reset_n;
      @(posedge clk_sys_in) !master_reset_n_sync |=> (pc == RESET_VEC && !fetch_out);
   endproperty
   a_master_reset_n: assert property (p_master_reset_n) else $error("not held in reset");

   property p_sfr_split;
      @(posedge clk_sys_in) disable iff (core_rst)
         dm_re_in |=> (dm_is_sfr_out == ($past(dm_addr_in) < DMEM_AW'(SFR_COUNT)));
   endproperty
   a_sfr_split: assert property (p_sfr_split) else $error("sfr flag wrong");

   property p_ee_ptr;
      @(posedge clk_sys_in) disable iff (core_rst)
         ee_ptr_we_in |=> (ee_ptr == $past(ee_ptr_in[EE_AW-1:0]));
   endproperty
   a_ee_ptr: assert property (p_ee_ptr) else $error("eeprom pointer wrong");

   property p_branch_load;
      @(posedge clk_sys_in) disable iff (core_rst)
         (fetch && branch_in && !irq_take_in) |=> (pc == $past(branch_addr_in));
   endproperty
   a_branch_load: assert property (p_branch_load) else $error("pc missed branch target");

   property p_fetch_flag;
      @(posedge clk_sys_in) disable iff (core_rst)
         fetch |=> fetch_out;
   endproperty
   a_fetch_flag: assert property (p_fetch_flag) else $error("fetch strobe missing");

   property p_fetch_src;
      @(posedge clk_sys_in) disable iff (core_rst)
         fetch_out |-> $past(fetch);
   endproperty
   a_fetch_src: assert property (p_fetch_src) else $error("fetch strobe without fetch");

   property p_instr_hold;
      @(posedge clk_sys_in) disable iff (core_rst)
         !fetch |=> $stable(instr_out);
   endproperty
   a_instr_hold: assert property (p_instr_hold) else $error("instruction word moved between fetches");

   property p_rate_off;
      @(posedge clk_sys_in) disable iff (core_rst)
         !rc_mode_in |=> !instr_rate_out;
   endproperty
   a_rate_off: assert property (p_rate_off) else $error("rate output active outside rc mode");

   property p_dm_hold;
      @(posedge clk_sys_in) disable iff (core_rst)
         !dm_re_in |=> $stable(dm_rdata_out) && $stable(dm_is_sfr_out);
   endproperty
   a_dm_hold: assert property (p_dm_hold) else $error("data read outputs moved without read");

   property p_ee_hold;
      @(posedge clk_sys_in) disable iff (core_rst)
         !ee_re_in |=> $stable(ee_rdata_out);
   endproperty
   a_ee_hold: assert property (p_ee_hold) else $error("eeprom read data moved without read");

   property p_ee_ptr_hold;
      @(posedge clk_sys_in) disable iff (core_rst)
         !ee_ptr_we_in |=> $stable(ee_ptr);
   endproperty
   a_ee_ptr_hold: assert property (p_ee_ptr_hold) else $error("eeprom pointer moved without load");

   property p_master_reset_n_sync;
      @(posedge clk_sys_in)
         !master_reset_n_in [*2] |=> core_rst;
   endproperty
   a_master_reset_n_sync: assert property (p_master_reset_n_sync) else $error("master reset not applied");

   property p_reset_release;
      @(posedge clk_sys_in)
         $fell(core_rst) |-> (pc == RESET_VEC && !fetch) ##1 !fetch ##1 !fetch ##1 fetch;
   endproperty
   a_reset_release: assert property (p_reset_release) else $error("first fetch after reset misplaced");

   property p_out_rst;
      @(posedge clk_sys_in)
         core_rst |=> (instr_out == '0) && !fetch_out && !instr_rate_out && (dm_rdata_out == '0) && (ee_rdata_out == '0);
   endproperty
   a_out_rst: assert property (p_out_rst) else $error("outputs not cleared by reset");

   property p_ptr_rst;
      @(posedge clk_sys_in)
         core_rst |=> (ee_ptr == '0);
   endproperty
   a_ptr_rst: assert property (p_ptr_rst) else $error("eeprom pointer not cleared by reset");

   property p_same_cycle;
      @(posedge clk_sys_in) disable iff (core_rst)
         (fetch && (dm_re_in || dm_we_in)) |=> fetch_out;
   endproperty
   a_same_cycle: assert property (p_same_cycle) else $error("data access blocked a fetch");

endmodule

/* File: test/pma_loader.sv */
// Program word loader on the far side
`timescale 1ns/100ps
module pma_loader
   import pma_pkg::*;
(
   // Clock and start
   input wire logic clk_sys_in,
   input wire logic go_in,
   // Load port
   output logic we_out,
   output logic [PC_W-1:0] addr_out,
   output logic [INSTR_W-1:0] wdata_out
);
   function automatic logic [INSTR_W-1:0] pat(int i);
      return 14'h2A5 ^ (14'(i) * 14'h111);
   endfunction
   initial begin
      we_out = 1'b0;
      addr_out = 13'h0000;
      wdata_out = 14'h0000;
      // Bounded start wait; loads anyway once it runs out
      for (int w = 0; w < 8 && !go_in; w++) begin
         @(negedge clk_sys_in);
      end
      for (int i = 0; i < 16; i++) begin
         @(negedge clk_sys_in);
         we_out = 1'b1;
         addr_out = 13'h1C00 + 13'(i);
         wdata_out = pat(i);
      end
      // Released lines toggle so a stale value is never trusted
      forever begin
         @(negedge clk_sys_in);
         we_out = 1'b0;
         addr_out = ~addr_out;
         wdata_out = ~wdata_out;
      end
   end
endmodule

/* File: test/program_memory_addressing_test.sv */
// Self-checking bench for the program memory addressing block
`timescale 1ns/100ps
module program_memory_addressing_test;
   import pma_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1, master_reset_n_in = 1'b1, rc_mode_in = 1'b0, branch_in = 1'b0, irq_take_in = 1'b0;
   logic dm_we_in = 1'b0, dm_re_in = 1'b0, ee_ptr_we_in = 1'b0, ee_we_in = 1'b0, ee_re_in = 1'b0, go = 1'b0;
   logic pm_we_in, instr_rate_out, fetch_out, dm_is_sfr_out;
   logic [PC_W-1:0] branch_addr_in = 13'h0000, pm_addr_in, pc_out;
   logic [INSTR_W-1:0] pm_wdata_in, instr_out;
   logic [INSTR_W-1:0] q[$];
   logic [DMEM_AW-1:0] dm_addr_in = 7'h00;
   logic [DATA_W-1:0] dm_wdata_in = 8'h00, ee_ptr_in = 8'h00, ee_wdata_in = 8'h00, dm_rdata_out, ee_rdata_out, k;
   logic [15:0] lf = 16'h9FB8;
   int miscompares = 0, comparisons = 0, n;
   int seq[3] = '{3, 4, 10};
   pma_core dut (.clk_sys_in, .rst_in, .master_reset_n_in, .rc_mode_in, .instr_rate_out, .branch_in,
      .branch_addr_in, .irq_take_in, .pc_out, .instr_out, .fetch_out, .pm_we_in, .pm_addr_in, .pm_wdata_in,
      .dm_we_in, .dm_re_in, .dm_addr_in, .dm_wdata_in, .dm_rdata_out, .dm_is_sfr_out, .ee_ptr_we_in,
      .ee_ptr_in, .ee_we_in, .ee_re_in, .ee_wdata_in, .ee_rdata_out);
   pma_loader u_ldr (.clk_sys_in, .go_in(go), .we_out(pm_we_in), .addr_out(pm_addr_in), .wdata_out(pm_wdata_in));
   always #12.5 clk_sys_in = ~clk_sys_in;
   task automatic cmp(logic [15:0] got, logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(logic [INSTR_W-1:0] got, logic [INSTR_W-1:0] exp);
      cmp(16'(got), 16'(exp));
   endtask
   task automatic cmp_pc(logic [PC_W-1:0] got, logic [PC_W-1:0] exp);
      cmp(16'(got), 16'(exp));
   endtask
   task automatic cmp_byte(logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
      cmp(16'(got), 16'(exp));
   endtask
   task automatic cmp_bit(logic got, logic exp);
      cmp(16'(got), 16'(exp));
   endtask
   function automatic logic [15:0] lfsr_next(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic test_done();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cyc(int c);
      repeat (c) @(negedge clk_sys_in);
   endtask
   // Bounded wait; master reset adds sync delay
   task automatic wait_fetch();
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (fetch_out !== 1'b1 && n < 12);
      if (n >= 12) begin
         miscompares++;
         $display("[ERR] %0t no fetch seen", $time);
         test_done();
      end
   endtask
   task automatic ee(logic [7:0] p, logic w, logic [7:0] v);
      ee_ptr_we_in = 1'b1;
      ee_ptr_in = p;
      cyc(1);
      ee_ptr_we_in = 1'b0;
      ee_we_in = w;
      ee_re_in = !w;
      ee_wdata_in = v;
      cyc(1);
      ee_we_in = 1'b0;
      ee_re_in = 1'b0;
      cyc(1);
   endtask
   // Fetch monitor: oldest expected word against each new fetch while the queue holds words
   always @(negedge clk_sys_in) begin
      if (fetch_out === 1'b1 && q.size() > 0) begin
         cmp_word(instr_out, q.pop_front());
      end
   end
   initial begin
      cyc(2);
      rst_in = 1'b0;
      go = 1'b1;
      cyc(20);
      rst_in = 1'b1;
      cyc(2);
      cmp_pc(pc_out, RESET_VEC);
      for (int i = 0; i < 3; i++) q.push_back(u_ldr.pat(i));
      rst_in = 1'b0;
      repeat (3) wait_fetch();
      foreach (seq[i]) q.push_back(u_ldr.pat(seq[i]));
      irq_take_in = 1'b1;
      branch_in = 1'b1;
      branch_addr_in = 13'h1C0A;
      cyc(4);
      irq_take_in = 1'b0;
      cmp_pc(pc_out, INT_VEC);
      cyc(4);
      branch_in = 1'b0;
      cmp_pc(pc_out, 13'h1C0A);
      cyc(4);
      cmp_pc(pc_out, 13'h1C0B);
      lf = lfsr_next(lf);
      dm_we_in = 1'b1;
      dm_addr_in = 7'h7F;
      dm_wdata_in = lf[7:0];
      cyc(1);
      dm_we_in = 1'b0;
      dm_re_in = 1'b1;
      cyc(1);
      cmp_byte(dm_rdata_out, lf[7:0]);
      for (int a = 11; a < 13; a++) begin
         dm_addr_in = 7'(a);
         cyc(1);
         cmp_bit(dm_is_sfr_out, a < 12);
      end
      dm_re_in = 1'b0;
      ee(8'hC5, 1'b1, lf[15:8]);
      ee(8'h3F, 1'b1, ~lf[15:8]);
      ee(8'h05, 1'b0, 8'h00);
      cmp_byte(ee_rdata_out, lf[15:8]);
      cmp_bit(instr_rate_out, 1'b0);
      rc_mode_in = 1'b1;
      cyc(4);
      for (int i = 0; i < 8; i++) begin
         cyc(1);
         k[i] = instr_rate_out;
      end
      cmp(16'(k[7:4]), 16'(k[3:0]));
      cmp(16'($countones(k[3:0])), 16'h0002);
      master_reset_n_in = 1'b0;
      cyc(5);
      cmp_pc(pc_out, RESET_VEC);
      cmp_bit(fetch_out, 1'b0);
      q.push_back(u_ldr.pat(0));
      master_reset_n_in = 1'b1;
      wait_fetch();
      // Let the monitor pop first; both wake on the same edge
      cyc(1);
      cmp(16'(q.size()), 16'h0000);
      test_done();
   end
endmodule
